/* File: core/acd_clock_control.sv */
// Purpose: Sample-clock divider, duty stabilizer control, power modes and
//   per-channel noise shaping requantizer settings and scaling.
// Assumes: Clock edges arrive as one-cycle ticks; all pins synchronous.
// Notes: Registers reached only through the serial port.
// Overview of operation
// RL1: Direct clock ticks divide by programmed integer ratio one to eight.
// RL2: RF clock ticks pass a fixed divide-by-four, then the same divider.
// RL3: Source select at clock_source_select and divide ratio at clock_divide_ratio, host written.
// RL4: Ratio other than one forces the duty stabilizer on.
// RL5: Link-mode bits 1 and 2 pick every sync pulse or first after write.
// RL6: Accepted sync pulse returns divider counters to initial state.
// RL7: Enabled and locked stabilizer regenerates falling edge, half period; code only sets the regen flag, conv_clk_phase stays the divider phase.
// RL8: Stabilizer never locks while input clock rate is below 40 MHz.
// RL9: Host waits up to 5 us relock after clock rate change.
// RL10: Unlocked stabilizer is bypassed; raw duty cycle passes through.
// RL11: Power-down when pin high or serial control set; pin low resumes.
// RL12: Power-down stops reference, buffer, bias, clock; standby keeps ref.
// RL13: Each of the two channels has its own requantizer settings.
// RL14: Mode value 0 selects narrow band, 22 percent of sample rate.
// RL15: Mode value 1 selects wide band, 33 percent of sample rate.
// RL16: Six-bit tuning value, 57 valid values, half-percent steps.
// RL17: Narrow band: low edge 0.005 times value, centre +0.11, top +0.22.
// RL18: Wide band: same low edge, centre +0.165, top +0.33.
// RL19: Enabled requantizer attenuates output by 0.6 dB.
// RL20: After reset the direct clock input is selected.
// RL21: Tuning values above the highest valid one act as the highest.
`timescale 1ns/10ps
module acd_clock_control
  import acd_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int SAMPLE_W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial port pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe,
  // Clock inputs as edge ticks, sync pulse, rate status
  input wire logic direct_clk_tick,
  input wire logic rf_clk_tick,
  input wire logic sysref_in,
  input wire logic clk_rate_ok,
  input wire logic clk_rate_change,
  // Power-down pin
  input wire logic power_down_request,
  // Converter clock
  output logic conv_clk_tick,
  output logic conv_clk_phase,
  output logic duty_cycle_stabilizer_regen,
  output logic duty_cycle_stabilizer_bypass,
  output logic duty_cycle_stabilizer_locked,
  // Power controls
  output logic ref_power_en,
  output logic ref_buf_en,
  output logic bias_en,
  output logic clk_power_en,
  // Per-channel requantizer
  input wire logic [NUM_CH*SAMPLE_W-1:0] sample_in,
  output logic [NUM_CH*SAMPLE_W-1:0] sample_out,
  output logic [NUM_CH-1:0] nsr_enable,
  output logic [NUM_CH-1:0] nsr_wide,
  output logic [NUM_CH*8-1:0] band_low,
  output logic [NUM_CH*8-1:0] band_center,
  output logic [NUM_CH*8-1:0] band_high
);
  if (NUM_CH < 1 || NUM_CH > 8 || SAMPLE_W < 2 || SAMPLE_W > 16) begin : g_chk
    $error("acd_clock_control: unsupported parameters");
  end

  logic reg_wr;
  logic [12:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] chan_sel_q;
  logic [7:0] power_q;
  logic [7:0] clk_src_q;
  logic [7:0] clk_div_q;
  logic [7:0] duty_ctrl_q;
  logic [7:0] link_mode_q;
  logic [NUM_CH*8-1:0] nsr_ctrl_q;
  logic [NUM_CH*8-1:0] nsr_tune_q;
  logic sync_armed_q;
  logic sysref_q;
  logic sync_hit;
  logic [1:0] prediv_q;
  logic [2:0] div_cnt_q;
  logic phase_q;
  logic in_tick;
  logic pd_active;
  logic standby;
  logic duty_active;
  logic [7:0] relock_q;
  logic ratio_one;

  // Serial register port
  acd_serial_port u_port (
    .clk(clk),
    .sys_rst(sys_rst),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_sdio_i(spi_sdio_i),
    .spi_sdio_o(spi_sdio_o),
    .spi_sdio_oe(spi_sdio_oe),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  // Global registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chan_sel_q <= ACD_RST_CHAN_SEL;
      power_q <= ACD_RST_POWER;
      clk_src_q <= ACD_RST_CLK_SRC; // [RL20]
      clk_div_q <= ACD_RST_CLK_DIV;
      duty_ctrl_q <= ACD_RST_DUTY_CTRL;
      link_mode_q <= ACD_RST_LINK_MODE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ACD_OFS_CHAN_SEL: chan_sel_q <= reg_wdata;
        ACD_OFS_POWER: power_q <= reg_wdata;
        ACD_OFS_CLK_SRC: clk_src_q <= reg_wdata; // [RL3]
        ACD_OFS_CLK_DIV: clk_div_q <= reg_wdata; // [RL3]
        ACD_OFS_DUTY_CTRL: duty_ctrl_q <= reg_wdata;
        ACD_OFS_LINK_MODE: link_mode_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Per-channel requantizer registers, written to every selected channel
  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_nsr_reg
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          nsr_ctrl_q[gc*8 +: 8] <= ACD_RST_NSR_CTRL;
          nsr_tune_q[gc*8 +: 8] <= ACD_RST_NSR_TUNE;
        end else if (reg_wr && chan_sel_q[gc]) begin // [RL13]
          if (reg_addr == ACD_OFS_NSR_CTRL) begin
            nsr_ctrl_q[gc*8 +: 8] <= reg_wdata;
          end
          if (reg_addr == ACD_OFS_NSR_TUNE) begin
            nsr_tune_q[gc*8 +: 8] <= {2'b00, reg_wdata[ACD_TUNE_MSB:0]};
          end
        end
      end
    end
  endgenerate

  // Read mux; first selected channel answers, unmapped reads zero
  always_comb begin
    reg_rdata = 8'h00;
    unique case (reg_addr)
      ACD_OFS_CHAN_SEL: reg_rdata = chan_sel_q;
      ACD_OFS_POWER: reg_rdata = power_q;
      ACD_OFS_CLK_SRC: reg_rdata = clk_src_q;
      ACD_OFS_CLK_DIV: reg_rdata = clk_div_q;
      ACD_OFS_DUTY_CTRL: reg_rdata = duty_ctrl_q;
      ACD_OFS_LINK_MODE: reg_rdata = link_mode_q;
      ACD_OFS_STATUS: reg_rdata = {4'h0, pd_active, sync_armed_q,
        duty_cycle_stabilizer_bypass, duty_cycle_stabilizer_locked};
      ACD_OFS_NSR_CTRL: begin
        for (int i = NUM_CH - 1; i >= 0; i--) begin
          if (chan_sel_q[i]) begin
            reg_rdata = nsr_ctrl_q[i*8 +: 8];
          end
        end
      end
      ACD_OFS_NSR_TUNE: begin
        for (int i = NUM_CH - 1; i >= 0; i--) begin
          if (chan_sel_q[i]) begin
            reg_rdata = nsr_tune_q[i*8 +: 8];
          end
        end
      end
      default: reg_rdata = 8'h00;
    endcase
  end

  // Sync pulse rising edge and one-shot arming
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sysref_q <= 1'b0;
      sync_armed_q <= 1'b0;
    end else begin
      sysref_q <= sysref_in;
      if (reg_wr && reg_addr == ACD_OFS_LINK_MODE) begin
        sync_armed_q <= 1'b1; // [RL5]
      end else if (sync_hit) begin
        sync_armed_q <= 1'b0;
      end
    end
  end
  assign sync_hit = sysref_in && !sysref_q &&
    link_mode_q[ACD_SYNC_EN_BIT] &&
    (link_mode_q[ACD_SYNC_EVERY_BIT] || sync_armed_q); // [RL5]

  // Fixed RF predivider
  always_ff @(posedge clk) begin
    if (sys_rst || sync_hit) begin
      prediv_q <= 2'd0; // [RL6]
    end else if (rf_clk_tick) begin
      prediv_q <= prediv_q + 2'd1; // [RL2]
    end
  end
  assign in_tick = clk_src_q[ACD_CLK_SRC_RF_BIT] ?
    (rf_clk_tick && prediv_q == 2'(ACD_RF_PREDIV - 1)) :
    direct_clk_tick; // [RL2]

  // Programmable 1-to-8 divider; ratio is field value plus one
  always_ff @(posedge clk) begin
    if (sys_rst || sync_hit) begin
      div_cnt_q <= 3'd0; // [RL6]
      conv_clk_tick <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      conv_clk_tick <= 1'b0;
      if (in_tick && clk_power_en) begin
        if (div_cnt_q == clk_div_q[2:0]) begin
          div_cnt_q <= 3'd0; // [RL1]
          conv_clk_tick <= 1'b1;
          phase_q <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 3'd1;
          if (div_cnt_q >= (clk_div_q[2:0] >> 1)) begin
            phase_q <= 1'b0;
          end
        end
      end
    end
  end

  // Duty stabilizer: forced on by ratio, lock after relock time
  assign ratio_one = clk_div_q[2:0] == 3'd0;
  assign duty_active = duty_ctrl_q[ACD_DUTY_EN_BIT] || !ratio_one; // [RL4]
  always_ff @(posedge clk) begin
    if (sys_rst || !clk_rate_ok || clk_rate_change || !clk_power_en ||
        (reg_wr && (reg_addr == ACD_OFS_CLK_SRC ||
        reg_addr == ACD_OFS_CLK_DIV))) begin
      relock_q <= 8'(ACD_RELOCK_CYC); // [RL8] [RL9]
    end else if (relock_q != 8'd0) begin
      relock_q <= relock_q - 8'd1;
    end
  end
  assign duty_cycle_stabilizer_locked = relock_q == 8'd0 && clk_rate_ok;
  assign duty_cycle_stabilizer_regen = duty_active &&
    duty_cycle_stabilizer_locked; // [RL7]
  assign duty_cycle_stabilizer_bypass = !duty_cycle_stabilizer_regen; // [RL10]
  // Divider phase drives the output, the same whether regenerated or not
  assign conv_clk_phase = phase_q;

  // Power-down and standby
  assign pd_active = power_down_request ||
    power_q[1:0] == ACD_PWR_DOWN; // [RL11]
  assign standby = !pd_active && power_q[1:0] == ACD_PWR_STANDBY;
  assign ref_power_en = !pd_active; // [RL12]
  assign ref_buf_en = !pd_active && !standby; // [RL12]
  assign bias_en = !pd_active && !standby;
  assign clk_power_en = !pd_active && !standby;

  // Per-channel band placement and output scaling
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_nsr
      logic [5:0] tune_c;
      logic [7:0] low_c;
      logic signed [SAMPLE_W-1:0] smp;
      logic signed [SAMPLE_W+16:0] prod;
      logic [SAMPLE_W-1:0] out_q;
      logic [7:0] low_q;
      logic [7:0] ctr_q;
      logic [7:0] high_q;
      assign tune_c = nsr_tune_q[gc*8 +: 6] > ACD_TUNE_MAX ?
        ACD_TUNE_MAX : nsr_tune_q[gc*8 +: 6]; // [RL16] [RL21]
      assign low_c = {2'b00, tune_c}; // [RL17] [RL18]
      assign nsr_enable[gc] = nsr_ctrl_q[gc*8 + ACD_NSR_EN_BIT];
      assign nsr_wide[gc] = nsr_ctrl_q[gc*8 + ACD_NSR_WIDE_BIT];
      assign smp = sample_in[gc*SAMPLE_W +: SAMPLE_W];
      assign prod = smp * $signed({1'b0, ACD_NSR_GAIN});
      // Band edges in half-percent units of the sample rate
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          low_q <= 8'h00;
          ctr_q <= 8'h00;
          high_q <= 8'h00;
        end else if (nsr_wide[gc]) begin
          low_q <= low_c;
          ctr_q <= low_c + ACD_WIDE_CTR; // [RL15] [RL18]
          high_q <= low_c + ACD_WIDE_SPAN;
        end else begin
          low_q <= low_c;
          ctr_q <= low_c + ACD_NARROW_CTR; // [RL14] [RL17]
          high_q <= low_c + ACD_NARROW_SPAN;
        end
      end
      // Sample scaling, 0.6 dB down while enabled
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          out_q <= '0;
        end else if (nsr_enable[gc]) begin
          out_q <= prod[SAMPLE_W+14:15]; // [RL19]
        end else begin
          out_q <= smp;
        end
      end
      assign band_low[gc*8 +: 8] = low_q;
      assign band_center[gc*8 +: 8] = ctr_q;
      assign band_high[gc*8 +: 8] = high_q;
      assign sample_out[gc*SAMPLE_W +: SAMPLE_W] = out_q;
    end
  endgenerate
endmodule // acd_clock_control

/* File: core/acd_pkg.sv */
// Purpose: Shared constants for the sample-clock and requantizer control.
// Assumes: 8-bit registers behind a 3-wire serial port, 13-bit addresses.
// Notes: Offsets of the power, duty, channel and status registers are local.
package acd_pkg;
  // Register offsets
  localparam logic [12:0] ACD_OFS_CHAN_SEL = 13'h0005;
  localparam logic [12:0] ACD_OFS_POWER = 13'h0008;
  localparam logic [12:0] ACD_OFS_CLK_SRC = 13'h0009;
  localparam logic [12:0] ACD_OFS_CLK_DIV = 13'h000B;
  localparam logic [12:0] ACD_OFS_DUTY_CTRL = 13'h0010;
  localparam logic [12:0] ACD_OFS_STATUS = 13'h0011;
  localparam logic [12:0] ACD_OFS_LINK_MODE = 13'h003A;
  localparam logic [12:0] ACD_OFS_NSR_CTRL = 13'h003C;
  localparam logic [12:0] ACD_OFS_NSR_TUNE = 13'h003E;
  // Field positions
  localparam int ACD_CLK_SRC_RF_BIT = 0;
  localparam int ACD_DUTY_EN_BIT = 0;
  localparam int ACD_SYNC_EN_BIT = 1;
  localparam int ACD_SYNC_EVERY_BIT = 2;
  localparam int ACD_NSR_EN_BIT = 0;
  localparam int ACD_NSR_WIDE_BIT = 1;
  localparam int ACD_TUNE_MSB = 5;
  // Reset values
  localparam logic [7:0] ACD_RST_CHAN_SEL = 8'h03;
  localparam logic [7:0] ACD_RST_POWER = 8'h00;
  localparam logic [7:0] ACD_RST_CLK_SRC = 8'h00;
  localparam logic [7:0] ACD_RST_CLK_DIV = 8'h00;
  localparam logic [7:0] ACD_RST_DUTY_CTRL = 8'h01;
  localparam logic [7:0] ACD_RST_LINK_MODE = 8'h00;
  localparam logic [7:0] ACD_RST_NSR_CTRL = 8'h00;
  localparam logic [7:0] ACD_RST_NSR_TUNE = 8'h00;
  // Power modes in the low bits of the power register
  typedef enum logic [1:0] {
    ACD_PWR_NORMAL = 2'h0,
    ACD_PWR_DOWN = 2'h1,
    ACD_PWR_STANDBY = 2'h2,
    ACD_PWR_RSVD = 2'h3
  } acd_pwr_mode_t;
  // Clock path
  localparam int ACD_RF_PREDIV = 4;
  localparam int ACD_DIV_MAX = 8;
  // Requantizer band, in half-percent steps of the sample rate
  localparam logic [5:0] ACD_TUNE_MAX = 6'd56;
  localparam logic [7:0] ACD_NARROW_CTR = 8'd22;
  localparam logic [7:0] ACD_NARROW_SPAN = 8'd44;
  localparam logic [7:0] ACD_WIDE_CTR = 8'd33;
  localparam logic [7:0] ACD_WIDE_SPAN = 8'd66;
  // 0.6 dB loss as a Q1.15 gain
  localparam logic [15:0] ACD_NSR_GAIN = 16'h7775;
  // Timing
  localparam int ACD_CLK_NS = 40;
  localparam int ACD_RELOCK_NS = 5000;
  localparam int ACD_RELOCK_CYC = ACD_RELOCK_NS / ACD_CLK_NS;
endpackage

/* File: core/acd_serial_port.sv */
// Purpose: 3-wire serial register port: 16-bit instruction, one data byte.
// Assumes: Port pins synchronous to clk, sclk well below clk/4.
// Notes: Data in on sclk rise, out on sclk fall, MSB first.
`timescale 1ns/10ps
module acd_serial_port
  import acd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe,
  // Register side
  output logic reg_wr,
  output logic [12:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  logic sclk_q;
  logic [4:0] cnt_q;
  logic [15:0] instr_q;
  logic [7:0] shift_q;
  logic rd_q;
  logic rise;
  logic fall;

  // Edge detect on the synchronous serial clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
    end
  end
  assign rise = spi_sclk & ~sclk_q & ~spi_cs_n;
  assign fall = ~spi_sclk & sclk_q & ~spi_cs_n;

  // Bit counter and shifting
  always_ff @(posedge clk) begin
    if (sys_rst || spi_cs_n) begin
      cnt_q <= 5'd0;
      instr_q <= 16'h0000;
      shift_q <= 8'h00;
      rd_q <= 1'b0;
    end else if (rise) begin
      if (cnt_q < 5'd16) begin
        instr_q <= {instr_q[14:0], spi_sdio_i};
      end else if (!rd_q) begin
        shift_q <= {shift_q[6:0], spi_sdio_i};
      end
      if (cnt_q != 5'd24) begin
        cnt_q <= cnt_q + 5'd1;
      end
    end else if (fall) begin
      if (cnt_q == 5'd16) begin
        rd_q <= instr_q[15];
        shift_q <= reg_rdata;
      end else if (rd_q && cnt_q > 5'd16) begin
        shift_q <= {shift_q[6:0], 1'b0};
      end
    end
  end

  // Write strobe once the data byte is complete
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_wr <= 1'b0;
      reg_wdata <= 8'h00;
    end else begin
      reg_wr <= rise && cnt_q == 5'd23 && !instr_q[15];
      reg_wdata <= {shift_q[6:0], spi_sdio_i};
    end
  end

  assign reg_addr = instr_q[12:0];
  assign spi_sdio_o = shift_q[7];
  assign spi_sdio_oe = rd_q & ~spi_cs_n;
endmodule // acd_serial_port

/* File: bench/acd_clock_control_props.sv */
// Purpose: Port-level checks for the clock control block.
// Assumes: Bound to acd_clock_control; one clock domain.
// Notes: Band relations watched on channel 0 only.
`timescale 1ns/10ps
module acd_clock_control_props
  import acd_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int SAMPLE_W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Clock path
  input wire logic direct_clk_tick,
  input wire logic rf_clk_tick,
  input wire logic clk_rate_ok,
  input wire logic clk_rate_change,
  input wire logic conv_clk_tick,
  input wire logic duty_cycle_stabilizer_regen,
  input wire logic duty_cycle_stabilizer_bypass,
  input wire logic duty_cycle_stabilizer_locked,
  // Power
  input wire logic power_down_request,
  input wire logic ref_power_en,
  input wire logic ref_buf_en,
  input wire logic bias_en,
  input wire logic clk_power_en,
  // Requantizer band
  input wire logic [NUM_CH-1:0] nsr_wide,
  input wire logic [NUM_CH*8-1:0] band_low,
  input wire logic [NUM_CH*8-1:0] band_center,
  input wire logic [NUM_CH*8-1:0] band_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Stabilizer lock relations
  property p_regen_locked;
    duty_cycle_stabilizer_regen |-> duty_cycle_stabilizer_locked;
  endproperty
  a_regen_locked: assert property (p_regen_locked)
    else $error("regen while unlocked");
  property p_bypass_unlocked;
    !duty_cycle_stabilizer_locked |-> duty_cycle_stabilizer_bypass;
  endproperty
  a_bypass_unlocked: assert property (p_bypass_unlocked)
    else $error("no bypass while unlocked");
  property p_slow_unlocked;
    (!clk_rate_ok ##1 !clk_rate_ok) |-> !duty_cycle_stabilizer_locked;
  endproperty
  a_slow_unlocked: assert property (p_slow_unlocked)
    else $error("locked on slow clock");
  property p_relock_wait;
    $rose(clk_rate_change) |=> !duty_cycle_stabilizer_locked [*8];
  endproperty
  a_relock_wait: assert property (p_relock_wait)
    else $error("lock held across rate change");
  // Power relations
  property p_pin_down;
    power_down_request [*2] |->
      !(ref_power_en || ref_buf_en || bias_en || clk_power_en);
  endproperty
  a_pin_down: assert property (p_pin_down)
    else $error("pin power-down left a supply on");
  property p_no_tick_down;
    (!clk_power_en ##1 !clk_power_en) |-> !conv_clk_tick;
  endproperty
  a_no_tick_down: assert property (p_no_tick_down)
    else $error("converter tick with clock off");
  property p_tick_cause;
    conv_clk_tick |-> $past(direct_clk_tick || rf_clk_tick);
  endproperty
  a_tick_cause: assert property (p_tick_cause)
    else $error("converter tick without input tick");
  // Band relations on channel 0
  property p_span;
    (!$past(sys_rst) && $stable(nsr_wide[0])) |->
      8'(band_high[7:0] - band_low[7:0]) == (nsr_wide[0] ? 8'h42 : 8'h2C);
  endproperty
  a_span: assert property (p_span)
    else $error("band span wrong");
  property p_centre;
    (!$past(sys_rst) && $stable(nsr_wide[0])) |->
      8'(band_center[7:0] - band_low[7:0]) == (nsr_wide[0] ? 8'h21 : 8'h16);
  endproperty
  a_centre: assert property (p_centre)
    else $error("band centre wrong");
  property p_tune_clamp;
    band_low[7:0] <= 8'h38;
  endproperty
  a_tune_clamp: assert property (p_tune_clamp)
    else $error("band low edge past top");
endmodule // acd_clock_control_props

/* File: bench/acd_host_model.sv */
// Purpose: Serial host and sync reference source.
// Assumes: sclk phases of three (low) or five (high) clk cycles, idle low.
// Notes: Drives a toggling pattern on sdio while the device answers.
`timescale 1ns/10ps
module acd_host_model
  import acd_pkg::*;
(
  // Clock
  input wire logic clk,
  // Serial pins
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic host_sdio,
  input wire logic sdio_wire,
  // Sync reference
  output logic sysref
);
  // Idle levels
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    host_sdio = 1'b0;
    sysref = 1'b0;
  end
  // One frame: read flag, spare bits, address, data, MSB first
  task automatic xfer(input logic rd, input logic [12:0] addr,
    input logic [7:0] wdat, output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, 2'h0, addr, wdat};
    rdat = 8'h00;
    @(posedge clk) spi_cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk) spi_sclk <= 1'b0;
      host_sdio <= (rd && i < 8) ? ~host_sdio : frame[i];
      repeat (3) @(posedge clk);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge clk);
      if (i < 8) rdat[i] = sdio_wire;
    end
    @(posedge clk) spi_sclk <= 1'b0;
    repeat (3) @(posedge clk);
    spi_cs_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Sync reference pulse
  task automatic pulse_sync();
    @(posedge clk) sysref <= 1'b1;
    repeat (2) @(posedge clk);
    sysref <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule // acd_host_model

/* File: bench/acd_clock_control_test.sv */
// Purpose: Self-checking bench for the clock control block.
// Assumes: Host model drives serial pins and sync reference.
// Notes: Expected values computed here with integers.
`timescale 1ns/10ps
module acd_clock_control_test
  import acd_pkg::*;
;
  logic clk, sys_rst, spi_cs_n, spi_sclk, host_sdio, sdio_wire, sysref;
  logic spi_sdio_o, spi_sdio_oe, direct_clk_tick, rf_clk_tick;
  logic clk_rate_ok, clk_rate_change, power_down_request, conv_clk_tick;
  logic regen, bypass, locked, ref_power_en, ref_buf_en, bias_en;
  logic clk_power_en;
  logic [21:0] sample_in, sample_out;
  logic [1:0] nsr_enable, nsr_wide;
  logic [15:0] band_low, band_center, band_high;
  int mismatches = 0;
  int num_checks = 0;
  int conv_cnt = 0;
  int c0;
  // Clock and wire resolution
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  assign sdio_wire = spi_sdio_oe ? spi_sdio_o : host_sdio;
  always @(posedge clk) if (conv_clk_tick === 1'b1) conv_cnt <= conv_cnt + 1;
  acd_clock_control #(.NUM_CH(2), .SAMPLE_W(11)) acd_clock_control_inst (
    .clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdio_i(sdio_wire), .spi_sdio_o(spi_sdio_o),
    .spi_sdio_oe(spi_sdio_oe), .direct_clk_tick(direct_clk_tick),
    .rf_clk_tick(rf_clk_tick), .sysref_in(sysref),
    .clk_rate_ok(clk_rate_ok), .clk_rate_change(clk_rate_change),
    .power_down_request(power_down_request), .conv_clk_tick(conv_clk_tick),
    .conv_clk_phase(), .duty_cycle_stabilizer_regen(regen),
    .duty_cycle_stabilizer_bypass(bypass),
    .duty_cycle_stabilizer_locked(locked), .ref_power_en(ref_power_en),
    .ref_buf_en(ref_buf_en), .bias_en(bias_en), .clk_power_en(clk_power_en),
    .sample_in(sample_in), .sample_out(sample_out), .nsr_enable(nsr_enable),
    .nsr_wide(nsr_wide), .band_low(band_low), .band_center(band_center),
    .band_high(band_high));
  acd_host_model acd_host_model_inst (.clk(clk), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .host_sdio(host_sdio), .sdio_wire(sdio_wire),
    .sysref(sysref));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    acd_host_model_inst.xfer(1'b0, a, d, q);
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    acd_host_model_inst.xfer(1'b1, a, 8'h00, q);
    check({8'h00, q}, {8'h00, e});
  endtask
  // Input clock edges with random gaps
  task automatic ticks(input logic rf, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      direct_clk_tick <= ~rf;
      rf_clk_tick <= rf;
      @(posedge clk);
      direct_clk_tick <= 1'b0;
      rf_clk_tick <= 1'b0;
      repeat ($urandom_range(0, 2)) @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  // Power mode from pin and register
  task automatic pwr_case(input logic pin, input logic [1:0] mode);
    logic pd;
    logic sb;
    @(posedge clk) power_down_request <= pin;
    wr(ACD_OFS_POWER, {6'h00, mode});
    pd = pin || mode == ACD_PWR_DOWN;
    sb = mode == ACD_PWR_STANDBY;
    check({15'h0, ref_power_en}, {15'h0, !pd});
    check({15'h0, clk_power_en}, {15'h0, !(pd || sb)});
    if (pd) check({14'h0, ref_buf_en, bias_en}, 16'h0000);
    c0 = conv_cnt;
    ticks(1'b0, 8);
    if (pd || sb) check(16'(conv_cnt - c0), 16'h0000);
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  // Main sequence
  initial begin
    int r, s, n, c, w, lo, v, e, ce, hi;
    int tw[2];
    logic en[2];
    logic wd[2];
    sys_rst = 1'b1;
    direct_clk_tick = 1'b0;
    rf_clk_tick = 1'b0;
    clk_rate_ok = 1'b1;
    clk_rate_change = 1'b0;
    power_down_request = 1'b0;
    sample_in = 22'h000000;
    s = $urandom(32'h4529);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd_chk(ACD_OFS_CLK_SRC, 8'h00);
    rd_chk(ACD_OFS_CLK_DIV, 8'h00);
    rd_chk(ACD_OFS_LINK_MODE, 8'h00);
    rd_chk(ACD_OFS_NSR_CTRL, 8'h00);
    rd_chk(ACD_OFS_NSR_TUNE, 8'h00);
    rd_chk(13'h01FF, 8'h00);
    $display("Test reset values done");
    wr(ACD_OFS_LINK_MODE, 8'h06);
    for (s = 0; s < 2; s++) begin
      for (r = 1; r <= 8; r++) begin
        wr(ACD_OFS_CLK_SRC, 8'(s));
        wr(ACD_OFS_CLK_DIV, 8'(r - 1));
        rd_chk(ACD_OFS_CLK_DIV, 8'(r - 1));
        acd_host_model_inst.pulse_sync();
        c0 = conv_cnt;
        n = $urandom_range(20, 40);
        ticks(s[0], n);
        check(16'(conv_cnt - c0), 16'(n / (s ? 4 * r : r)));
      end
    end
    $display("Test divider done");
    wr(ACD_OFS_CLK_SRC, 8'h00);
    wr(ACD_OFS_CLK_DIV, 8'h03);
    for (w = 0; w < 2; w++) begin
      wr(ACD_OFS_LINK_MODE, w ? 8'h06 : 8'h02);
      acd_host_model_inst.pulse_sync();
      ticks(1'b0, 3);
      c0 = conv_cnt;
      acd_host_model_inst.pulse_sync();
      ticks(1'b0, 3);
      check(16'(conv_cnt - c0), w ? 16'h0000 : 16'h0001);
    end
    $display("Test sync done");
    wr(ACD_OFS_DUTY_CTRL, 8'h00);
    for (r = 1; r <= 2; r++) begin
      wr(ACD_OFS_CLK_DIV, 8'(r - 1));
      repeat (ACD_RELOCK_CYC + 10) @(posedge clk);
      check({14'h0, locked, regen}, {14'h0, 1'b1, r == 2});
      clk_rate_ok <= 1'b0;
      repeat (10) @(posedge clk);
      check({15'h0, locked}, 16'h0000);
      if (r == 2) check({15'h0, bypass}, 16'h0001);
      clk_rate_ok <= 1'b1;
      clk_rate_change <= 1'b1;
      @(posedge clk);
      clk_rate_change <= 1'b0;
    end
    $display("Test stabilizer done");
    pwr_case(1'b0, ACD_PWR_DOWN);
    pwr_case(1'b1, ACD_PWR_NORMAL);
    pwr_case(1'b0, ACD_PWR_STANDBY);
    pwr_case(1'b0, ACD_PWR_NORMAL);
    $display("Test power done");
    for (w = 0; w < 2; w++) begin
      for (c = 0; c < 2; c++) begin
        en[c] = (c == 0) || w;
        wd[c] = 1'(c ^ w);
        tw[c] = (w == 0 && c == 0) ? 63 : $urandom_range(0, 63);
        wr(ACD_OFS_CHAN_SEL, 8'(1 << c));
        wr(ACD_OFS_NSR_CTRL, {6'h00, wd[c], en[c]});
        wr(ACD_OFS_NSR_TUNE, 8'(tw[c]));
      end
      for (c = 0; c < 2; c++) begin
        lo = tw[c] > 56 ? 56 : tw[c];
        ce = lo + (wd[c] ? 33 : 22);
        hi = lo + (wd[c] ? 66 : 44);
        check({15'h0, nsr_enable[c]}, {15'h0, en[c]});
        check({15'h0, nsr_wide[c]}, {15'h0, wd[c]});
        check({8'h0, band_low[c*8 +: 8]}, 16'(lo));
        check({8'h0, band_center[c*8 +: 8]}, 16'(ce));
        check({8'h0, band_high[c*8 +: 8]}, 16'(hi));
      end
      for (n = 0; n < 16; n++) begin
        @(posedge clk) sample_in <= 22'($urandom);
        @(posedge clk);
        #1;
        for (c = 0; c < 2; c++) begin
          v = $signed(sample_in[c*11 +: 11]);
          e = en[c] ? (v * int'(ACD_NSR_GAIN)) >>> 15 : v;
          check({5'h0, sample_out[c*11 +: 11]}, {5'h0, 11'(e)});
        end
      end
    end
    $display("Test requantizer done");
    stop_test();
  end
endmodule // acd_clock_control_test

bind acd_clock_control acd_clock_control_props #(
  .NUM_CH(NUM_CH),
  .SAMPLE_W(SAMPLE_W)
) acd_clock_control_props_inst (
  .clk(clk), .sys_rst(sys_rst), .direct_clk_tick(direct_clk_tick),
  .rf_clk_tick(rf_clk_tick), .clk_rate_ok(clk_rate_ok),
  .clk_rate_change(clk_rate_change), .conv_clk_tick(conv_clk_tick),
  .duty_cycle_stabilizer_regen(duty_cycle_stabilizer_regen),
  .duty_cycle_stabilizer_bypass(duty_cycle_stabilizer_bypass),
  .duty_cycle_stabilizer_locked(duty_cycle_stabilizer_locked),
  .power_down_request(power_down_request), .ref_power_en(ref_power_en),
  .ref_buf_en(ref_buf_en), .bias_en(bias_en), .clk_power_en(clk_power_en),
  .nsr_wide(nsr_wide), .band_low(band_low), .band_center(band_center),
  .band_high(band_high));
